// ==== rtl/parc_pkg.sv ====
// Package: constants and carriers for the pixel array readout control block
package parc_pkg;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned PIX_W = 10;
    localparam int unsigned GAIN_W = 2;
    localparam int unsigned ROWS = 512;
    localparam int unsigned COLS = 512;
    // AHB register offsets (byte addresses)
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_CLK = 12'h008;
    localparam logic [11:0] OFF_STAT = 12'h00c;
    localparam logic [11:0] OFF_POS = 12'h010;
    localparam logic [11:0] OFF_ADC = 12'h014;
    localparam logic [11:0] OFF_SAMPLE = 12'h018;
    // CTRL field positions
    localparam int unsigned CTRL_ROW_EN = 0;
    localparam int unsigned CTRL_ROW_RST = 1;
    localparam int unsigned CTRL_SIDE = 2;
    localparam int unsigned CTRL_ROW_LOAD = 3;
    localparam int unsigned CTRL_COL_LOAD = 4;
    localparam int unsigned CTRL_TRIM = 5;
    localparam int unsigned CTRL_GAIN_LO = 6;
    localparam int unsigned CTRL_FLIP = 8;
    localparam int unsigned CTRL_HIZ = 9;
    localparam int unsigned CTRL_SAMP = 10;
    localparam int unsigned CTRL_REF = 11;
    // CLK (pin level) field positions
    localparam int unsigned PIN_LCLK = 0;
    localparam int unsigned PIN_RCLK = 1;
    localparam int unsigned PIN_CCLK = 2;
    localparam int unsigned PIN_ADCCLK = 3;
    localparam int unsigned PIN_LPRE_N = 4;
    localparam int unsigned PIN_RPRE_N = 5;
    localparam int unsigned PIN_CPRE_N = 6;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0019;
    localparam logic [31:0] PINS_RST = 32'h0000_0070;
    localparam logic [31:0] DEAD_VAL = 32'h0000_0000;
    // Shift register pointer carrier
    typedef struct packed {
        logic [ADDR_W-1:0] pos;
        logic active;
    } parc_ptr_t;
    typedef enum logic [1:0] {
        PARC_G1,
        PARC_G2,
        PARC_G4,
        PARC_G8
    } parc_gain_t;
endpackage

// ==== rtl/parc_shift.sv ====
// Edge-driven position shift register with preset and end-of-scan pulse
module parc_shift
    import parc_pkg::*;
#(
    parameter int unsigned LEN = 512
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic shift_clk,
    input wire logic preset_n,
    input wire logic [parc_pkg::ADDR_W-1:0] start_pos,
    output parc_pkg::parc_ptr_t ptr,
    output logic scan_done_n
);
    import parc_pkg::*;

    logic clk_d_r;
    logic fall;
    logic at_last;
    logic pass_r;
    parc_ptr_t ptr_r;
    parc_ptr_t ptr_nxt;

    // Edge and last-position detection
    assign fall = clk_d_r & ~shift_clk;
    assign at_last = (ptr_r.pos == ADDR_W'(LEN - 1));

    // Preset wins over a shift; passing the last position deactivates
    always_comb begin
        ptr_nxt = ptr_r;
        if (!preset_n) begin
            ptr_nxt.pos = start_pos;
            ptr_nxt.active = 1'b1;
        end else if (fall && ptr_r.active) begin
            if (at_last) begin
                ptr_nxt.active = 1'b0;
            end else begin
                ptr_nxt.pos = ptr_r.pos + ADDR_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_d_r <= 1'b0;
            ptr_r <= '0;
            pass_r <= 1'b0;
        end else begin
            clk_d_r <= shift_clk;
            ptr_r <= ptr_nxt;
            pass_r <= preset_n & fall & ptr_r.active & at_last;
        end
    end

    // Low for one shift period after passing the end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scan_done_n <= 1'b1;
        end else if (pass_r) begin
            scan_done_n <= 1'b0;
        end else if (fall || !preset_n) begin
            scan_done_n <= 1'b1;
        end
    end

    assign ptr = ptr_r;
endmodule

// ==== rtl/parc_top.sv ====
// Pixel array readout control: AHB-Lite register front end and pointer logic
module parc_top
    import parc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [parc_pkg::PIX_W-1:0] conv_sample,
    output logic [parc_pkg::PIX_W-1:0] pixel_out,
    output logic [parc_pkg::PIX_W-1:0] pixel_oe,
    output logic row_select,
    output logic row_reset,
    output logic [parc_pkg::ADDR_W-1:0] row_pos,
    output logic [parc_pkg::ADDR_W-1:0] col_pos,
    output logic pixel_valid,
    output logic dark_level_ref,
    output logic [parc_pkg::GAIN_W-1:0] amp_gain,
    output logic sample_strobe,
    output logic ref_strobe,
    output logic column_scan_done_n,
    output logic left_scan_done_n,
    output logic right_scan_done_n
);
    import parc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    logic [31:0] ctrl_r;
    logic [31:0] pins_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] row_start_r;
    logic [ADDR_W-1:0] col_start_r;
    logic [PIX_W-1:0] result_r;
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] rdata_nxt;
    logic acc;
    logic rd_acc;

    assign acc = hsel & hready & htrans[1];
    assign rd_acc = acc & ~hwrite;

    // Pointers of the three shift registers; their active flags are read back in the status word
    parc_ptr_t lptr;
    parc_ptr_t rptr;
    parc_ptr_t cptr;

    // Write hits, from the address captured in the address phase
    logic wr_hit_ctrl;
    logic wr_hit_addr;
    logic wr_hit_pins;
    assign wr_hit_ctrl = (wr_addr_r == OFF_CTRL);
    assign wr_hit_addr = (wr_addr_r == OFF_ADDR);
    assign wr_hit_pins = (wr_addr_r == OFF_CLK);

    // Read hits, from the live address phase
    logic rd_hit_ctrl;
    logic rd_hit_addr;
    logic rd_hit_pins;
    logic rd_hit_stat;
    logic rd_hit_pos;
    logic rd_hit_adc;
    logic rd_hit_sample;
    assign rd_hit_ctrl = (haddr[11:0] == OFF_CTRL);
    assign rd_hit_addr = (haddr[11:0] == OFF_ADDR);
    assign rd_hit_pins = (haddr[11:0] == OFF_CLK);
    assign rd_hit_stat = (haddr[11:0] == OFF_STAT);
    assign rd_hit_pos = (haddr[11:0] == OFF_POS);
    assign rd_hit_adc = (haddr[11:0] == OFF_ADC);
    assign rd_hit_sample = (haddr[11:0] == OFF_SAMPLE);

    // Read-only status and position words
    logic [31:0] stat_word;
    logic [31:0] pos_word;
    assign stat_word = {25'h0, pixel_valid, column_scan_done_n, right_scan_done_n,
        left_scan_done_n, lptr.active, rptr.active, cptr.active};
    assign pos_word = {5'h0, col_start_r, row_start_r, col_pos};

    // Address phase capture for writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else begin
            wr_pend_r <= acc & hwrite;
            wr_addr_r <= haddr[11:0];
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RST;
            pins_r <= PINS_RST;
            addr_r <= '0;
        end else if (wr_pend_r) begin
            if (wr_hit_ctrl) begin
                ctrl_r <= hwdata;
            end else if (wr_hit_addr) begin
                addr_r <= hwdata[ADDR_W-1:0];
            end else if (wr_hit_pins) begin
                pins_r <= hwdata;
            end
        end
    end

    // Read mux, unmapped reads as zero
    always_comb begin
        rdata_nxt = DEAD_VAL;
        if (rd_hit_ctrl) begin
            rdata_nxt = ctrl_r;
        end else if (rd_hit_addr) begin
            rdata_nxt = {23'h0, addr_r};
        end else if (rd_hit_pins) begin
            rdata_nxt = pins_r;
        end else if (rd_hit_stat) begin
            rdata_nxt = stat_word;
        end else if (rd_hit_pos) begin
            rdata_nxt = pos_word;
        end else if (rd_hit_adc) begin
            rdata_nxt = {22'h0, result_r};
        end else if (rd_hit_sample) begin
            rdata_nxt = {22'h0, pixel_out};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= '0;
        end else if (rd_acc) begin
            hrdata <= rdata_nxt;
        end
    end

    // Zero-wait OKAY slave, ready and response held in flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start registers: transparent while load low, hold while high
    logic row_load;
    logic col_load;
    assign row_load = ctrl_r[CTRL_ROW_LOAD];
    assign col_load = ctrl_r[CTRL_COL_LOAD];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            row_start_r <= '0;
            col_start_r <= '0;
        end else begin
            if (!row_load) begin
                row_start_r <= addr_r;
            end
            if (!col_load) begin
                col_start_r <= addr_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift registers: left rows, right rows, columns

    // Left rows, falling-edge shift, active-low preset
    parc_shift #(.LEN(ROWS)) u_left (
        .clk(clk),
        .resetn(resetn),
        .shift_clk(pins_r[PIN_LCLK]),
        .preset_n(pins_r[PIN_LPRE_N]),
        .start_pos(row_start_r),
        .ptr(lptr),
        .scan_done_n(left_scan_done_n)
    );

    // Right rows
    parc_shift #(.LEN(ROWS)) u_right (
        .clk(clk),
        .resetn(resetn),
        .shift_clk(pins_r[PIN_RCLK]),
        .preset_n(pins_r[PIN_RPRE_N]),
        .start_pos(row_start_r),
        .ptr(rptr),
        .scan_done_n(right_scan_done_n)
    );

    // Columns
    parc_shift #(.LEN(COLS)) u_col (
        .clk(clk),
        .resetn(resetn),
        .shift_clk(pins_r[PIN_CCLK]),
        .preset_n(pins_r[PIN_CPRE_N]),
        .start_pos(col_start_r),
        .ptr(cptr),
        .scan_done_n(column_scan_done_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Row select and reset from the chosen side
    parc_ptr_t side_ptr;
    logic sel_nxt;
    logic rst_nxt;
    assign side_ptr = ctrl_r[CTRL_SIDE] ? lptr : rptr;
    assign sel_nxt = ctrl_r[CTRL_ROW_EN] & side_ptr.active;
    assign rst_nxt = ctrl_r[CTRL_ROW_RST] & side_ptr.active;

    // Amplifier gain, forced to unity during offset trim
    logic trim;
    logic [GAIN_W-1:0] gain_nxt;
    assign trim = ctrl_r[CTRL_TRIM];
    assign gain_nxt = trim ? GAIN_W'(PARC_G1) : ctrl_r[CTRL_GAIN_LO +: GAIN_W];

    // Converter: one sample per converter clock falling edge
    logic adc_d_r;
    logic adc_fall;
    logic [PIX_W-1:0] out_nxt;
    assign adc_fall = adc_d_r & ~pins_r[PIN_ADCCLK];
    assign out_nxt = ctrl_r[CTRL_FLIP] ? ~result_r : result_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            adc_d_r <= 1'b0;
            result_r <= '0;
        end else begin
            adc_d_r <= pins_r[PIN_ADCCLK];
            if (adc_fall) begin
                result_r <= trim ? '0 : conv_sample;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel valid and output enable ahead of their flops
    logic valid_nxt;
    logic [PIX_W-1:0] oe_nxt;
    assign valid_nxt = cptr.active & ~pins_r[PIN_CCLK] & ~trim;
    assign oe_nxt = {PIX_W{~ctrl_r[CTRL_HIZ]}};

    // Registered outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            row_select <= 1'b0;
            row_reset <= 1'b0;
            row_pos <= '0;
            col_pos <= '0;
            pixel_valid <= 1'b0;
            dark_level_ref <= 1'b0;
            amp_gain <= '0;
            sample_strobe <= 1'b0;
            ref_strobe <= 1'b0;
            pixel_out <= '0;
            pixel_oe <= '0;
        end else begin
            row_select <= sel_nxt;
            row_reset <= rst_nxt;
            row_pos <= side_ptr.pos;
            col_pos <= cptr.pos;
            pixel_valid <= valid_nxt;
            dark_level_ref <= trim;
            amp_gain <= gain_nxt;
            sample_strobe <= ctrl_r[CTRL_SAMP];
            ref_strobe <= ctrl_r[CTRL_REF];
            pixel_out <= out_nxt;
            pixel_oe <= oe_nxt;
        end
    end
endmodule

// ==== tb/parc_top_checker.sv ====
// Checker: port-level properties of the readout control block
module parc_top_checker
    import parc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [parc_pkg::PIX_W-1:0] pixel_oe,
    input wire logic pixel_valid,
    input wire logic dark_level_ref,
    input wire logic [parc_pkg::GAIN_W-1:0] amp_gain,
    input wire logic sample_strobe,
    input wire logic ref_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dck @(posedge clk); endclocking
    default disable iff (!resetn);
    // Control word write taken on the bus
    wire ctrl_wr = hsel && hready && htrans[1] && hwrite && haddr == 32'(OFF_CTRL);
    ////////////////////////////////////////
    // Outputs settle three edges after the address phase
    gain_follow_a: assert property (ctrl_wr ##3 1 |-> amp_gain ==
        ($past(hwdata[CTRL_TRIM], 2) ? 2'b00 : $past(hwdata[CTRL_GAIN_LO +: 2], 2)))
        else $error("gain not taken from control word");
    trim_dark_a: assert property (ctrl_wr ##3 1 |->
        dark_level_ref == $past(hwdata[CTRL_TRIM], 2)) else $error("dark reference wrong");
    hiz_float_a: assert property (ctrl_wr ##3 1 |->
        pixel_oe == {PIX_W{!$past(hwdata[CTRL_HIZ], 2)}}) else $error("output enable wrong");
    strobe_copy_a: assert property (ctrl_wr ##3 1 |->
        {ref_strobe, sample_strobe} == $past(hwdata[CTRL_SAMP +: 2], 2))
        else $error("strobes not copied");
    oe_whole_a: assert property (pixel_oe == '0 || pixel_oe == '1)
        else $error("output enables split");
    trim_unity_a: assert property (dark_level_ref |-> amp_gain == 2'b00)
        else $error("gain not unity in trim");
    trim_invalid_a: assert property (dark_level_ref |-> !pixel_valid)
        else $error("pixel valid during trim");
    gain_hold_a: assert property (!ctrl_wr [*4] |-> $stable({amp_gain, dark_level_ref}))
        else $error("gain moved without write");
endmodule
bind parc_top parc_top_checker chk_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .pixel_oe(pixel_oe),
    .pixel_valid(pixel_valid), .dark_level_ref(dark_level_ref), .amp_gain(amp_gain),
    .sample_strobe(sample_strobe), .ref_strobe(ref_strobe));

// ==== tb/parc_adc_model.sv ====
// Converter input model: stepping pattern, or a held level on demand
module parc_adc_model
    import parc_pkg::*;
(
    input wire logic clk,
    input wire logic freeze,
    input wire logic [parc_pkg::PIX_W-1:0] level,
    output logic [parc_pkg::PIX_W-1:0] conv_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [parc_pkg::PIX_W-1:0] walk_r = 10'h155;
    // Steps each cycle so a mistimed capture cannot match by luck
    always_ff @(posedge clk) begin
        walk_r <= walk_r + 10'h1d5;
    end
    assign conv_sample = freeze ? level : walk_r;
endmodule

// ==== tb/parc_top_tb_top.sv ====
// Testbench: register-driven scenarios for the readout control block
module parc_top_tb_top
    import parc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, hsel, hwrite, hreadyout, hresp, freeze;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [PIX_W-1:0] conv_sample, pixel_out, pixel_oe;
    logic [ADDR_W-1:0] row_pos, col_pos;
    logic [GAIN_W-1:0] amp_gain;
    logic row_select, row_reset, pixel_valid, dark_level_ref, sample_strobe, ref_strobe;
    logic col_done_n, left_done_n, right_done_n;
    int error_cnt = 0;
    int n_checks = 0;
    localparam logic [PIX_W-1:0] LEVEL = 10'h2c3;
    parc_top dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_sample(conv_sample), .pixel_out(pixel_out),
        .pixel_oe(pixel_oe), .row_select(row_select), .row_reset(row_reset), .row_pos(row_pos),
        .col_pos(col_pos), .pixel_valid(pixel_valid), .dark_level_ref(dark_level_ref),
        .amp_gain(amp_gain), .sample_strobe(sample_strobe), .ref_strobe(ref_strobe),
        .column_scan_done_n(col_done_n), .left_scan_done_n(left_done_n),
        .right_scan_done_n(right_done_n));
    parc_adc_model adc_u (.clk(clk), .freeze(freeze), .level(LEVEL), .conv_sample(conv_sample));
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    // Write, then let the effect reach the pins
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        repeat (6) @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk("rdata", exp, q);
    endtask
    // Clock high, preset low, preset released, clock still high
    task automatic pins3(input logic [31:0] hi, input logic [31:0] lo);
        wr(OFF_CLK, hi);
        wr(OFF_CLK, lo);
        wr(OFF_CLK, hi);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // Scenarios
    initial begin
        {resetn, hsel, hwrite, freeze} = '0;
        htrans = 2'b00;
        haddr = '0;
        hwdata = '0;
        hsize = 3'b010;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("done_n", 32'h7, {29'h0, col_done_n, left_done_n, right_done_n});
        rd(OFF_CTRL, CTRL_RST);
        rd(OFF_CLK, PINS_RST);
        for (int g = 0; g < 4; g++) begin
            wr(OFF_CTRL, 32'h19 | (g << 6));
            chk("amp_gain", g, 32'(amp_gain));
        end
        wr(OFF_CTRL, 32'hcf9);
        chk("dark_ref", 32'h1, 32'(dark_level_ref));
        chk("trim_gain", 32'h0, 32'(amp_gain));
        chk("strobes", 32'h3, {30'h0, ref_strobe, sample_strobe});
        wr(OFF_CTRL, 32'h01);
        wr(OFF_ADDR, 32'h1a5);
        wr(OFF_CTRL, 32'h19);
        wr(OFF_ADDR, 32'h0f0);
        bus(1'b0, OFF_POS, 32'h0);
        chk("starts", {14'h0, 9'h1a5, 9'h1a5}, {14'h0, q[26:9]});
        pins3(32'h74, 32'h34);
        chk("col_pos", 32'h1a5, 32'(col_pos));
        wr(OFF_CLK, 32'h70);
        chk("col_step", 32'h1a6, 32'(col_pos));
        chk("valid_low", 32'h1, 32'(pixel_valid));
        rd(OFF_STAT, 32'h79);
        wr(OFF_CLK, 32'h74);
        chk("valid_high", 32'h0, 32'(pixel_valid));
        wr(OFF_CTRL, 32'h1d);
        pins3(32'h71, 32'h61);
        chk("left_pos", 32'h1a5, 32'(row_pos));
        chk("left_sel", 32'h1, 32'(row_select));
        wr(OFF_CLK, 32'h70);
        chk("left_step", 32'h1a6, 32'(row_pos));
        wr(OFF_CTRL, 32'h1f);
        chk("row_reset", 32'h1, 32'(row_reset));
        wr(OFF_CTRL, 32'h19);
        chk("right_idle", 32'h0, 32'(row_select));
        pins3(32'h72, 32'h52);
        wr(OFF_CLK, 32'h70);
        chk("right_step", 32'h1a6, 32'(row_pos));
        chk("right_sel", 32'h1, 32'(row_select));
        wr(OFF_CTRL, 32'h01);
        wr(OFF_ADDR, 32'h1ff);
        wr(OFF_CTRL, 32'h19);
        pins3(32'h76, 32'h16);
        wr(OFF_CLK, 32'h70);
        chk("col_done", 32'h0, 32'(col_done_n));
        chk("right_done", 32'h0, 32'(right_done_n));
        // Left register run past the last row as well
        wr(OFF_CTRL, 32'h1d);
        pins3(32'h71, 32'h61);
        wr(OFF_CLK, 32'h70);
        chk("left_done", 32'h0, 32'(left_done_n));
        chk("left_gone", 32'h0, 32'(row_select));
        freeze <= 1'b1;
        wr(OFF_CLK, 32'h78);
        wr(OFF_CLK, 32'h70);
        chk("pixel", 32'h2c3, 32'(pixel_out));
        chk("oe_on", 32'h3ff, 32'(pixel_oe));
        rd(OFF_ADC, 32'h2c3);
        wr(OFF_CTRL, 32'h119);
        chk("flipped", 32'h13c, 32'(pixel_out));
        rd(OFF_SAMPLE, 32'h13c);
        wr(OFF_CTRL, 32'h219);
        chk("oe_off", 32'h0, 32'(pixel_oe));
        wr(12'h0fc, 32'hffff_ffff);
        rd(12'h0fc, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        chk("done_n_rst", 32'h7, {29'h0, col_done_n, left_done_n, right_done_n});
        rd(OFF_CTRL, CTRL_RST);
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
